// ### inc/hstf_regs.svh
`ifndef HSTF_REGS_SVH
`define HSTF_REGS_SVH

// Register addresses on the four-bit CPU address.
`define HSTF_ADDR_FIFO_STAT 4'h0
`define HSTF_ADDR_RX_DATA 4'h1
`define HSTF_ADDR_TX_DATA 4'h1
`define HSTF_ADDR_CONTROL 4'h2
`define HSTF_ADDR_CCH_CTRL 4'h3
`define HSTF_ADDR_TIMING 4'h4
`define HSTF_ADDR_WATCHDOG 4'h5
`define HSTF_ADDR_CCH_STATUS 4'h6

// Field positions.
`define HSTF_CTRL_FILL_MSB 3
`define HSTF_CTRL_FILL_LSB 2

// Reset values.
`define HSTF_CONTROL_RST 8'h00
`define HSTF_CCH_CTRL_RST 8'hFF
`define HSTF_TIMING_RST 8'h00
`define HSTF_FIFO_STAT_RST 8'h08

// Watchdog clear key: low five bits must match.
`define HSTF_WD_KEY_MASK 8'h1F
`define HSTF_WD_KEY_VALUE 8'h0A

// Fill thresholds and status delays in falling clock edges.
`define HSTF_RX_HIGH_MARK 15
`define HSTF_TX_HIGH_MARK 5
`define HSTF_STAT_EDGES_SLOW 2
`define HSTF_STAT_EDGES_FAST 4

// Frame layout: eight bits per channel, the control channel is channel one.
`define HSTF_CTRL_CHANNEL 5'h01
`define HSTF_FIRST_DATA_CHANNEL 5'h02

`endif

// ### inc/hstf_pkg.sv
package hstf_pkg;

    typedef struct packed {
        logic sel;
        logic write;
        logic [3:0] addr;
        logic [7:0] data;
    } hstf_cpu_req_t;

    typedef struct packed {
        logic swReset;
        logic internalTiming;
        logic ctrlChannelTxEnable;
        logic clockRateSelect;
        logic [3:0] timeslotSelect;
    } hstf_timing_t;

    typedef struct packed {
        logic [1:0] byteStatus;
        logic [7:0] data;
    } hstf_rx_entry_t;

    typedef enum logic [1:0] {
        HSTF_FILL_IDLE = 2'b00,
        HSTF_FILL_FLAGS = 2'b01,
        HSTF_FILL_TRANSP = 2'b10,
        HSTF_FILL_GOAHEAD = 2'b11
    } hstf_fill_t;

endpackage

// ### hdl/hstf_top.sv
`timescale 1ns/1ps
`include "hstf_regs.svh"
module hstf_top #(
    parameter int FIFO_DEPTH = 19
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire hstf_pkg::hstf_cpu_req_t cpuReq,
    output logic [7:0] cpuRdData,
    input wire logic serialClockIn,
    input wire logic framePulseInN,
    input wire logic txBitGateN,
    input wire logic rxBitGateN,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutOeN,
    output logic watchdogAlarmN
);
    import hstf_pkg::*;

    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam logic [4:0] SYNC_IDLE = 5'h1E;

    logic [4:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
    logic clkPrev_reg, fpPrev_reg;
    logic [7:0] control_reg, cchCtrl_reg, cchStatus_reg, cchShift_reg;
    hstf_timing_t timing_reg;
    logic halfPhase_reg, fpSeen_reg, rxOpen_reg;
    logic [7:0] bitPos_reg;
    logic serialOut_reg, serialOutOeN_reg;
    logic [7:0] txShift_reg, rxShift_reg, lastWritten_reg;
    logic [3:0] txCnt_reg, rxCnt_reg;
    logic [7:0] txMem [FIFO_DEPTH];
    hstf_rx_entry_t rxMem [FIFO_DEPTH];
    logic [CW-1:0] txWr_reg, txRd_reg, txCount_reg, rxWr_reg, rxRd_reg, rxCount_reg;
    logic [2:0] statDelay_reg;
    logic [7:0] fifoStat_reg, cpuRdData_reg;
    logic [10:0] wdCnt_reg;
    logic wdAlarmN_reg;

    function automatic logic [CW-1:0] ptrInc(input logic [CW-1:0] p);
        return (p == CW'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    function automatic logic [3:0] slotBits(input logic [3:0] tc);
        case (tc)
            4'h0: return 4'h1;
            4'h1: return 4'h2;
            4'h2: return 4'h6;
            4'h3: return 4'h7;
            default: return 4'h8;
        endcase
    endfunction

    // Narrow selections live in the first data channel, full ones step up from it.
    function automatic logic [4:0] slotChan(input logic [3:0] tc);
        return (tc < 4'h4) ? `HSTF_FIRST_DATA_CHANNEL : {1'b0, tc} - 5'h02;
    endfunction

    // Three flops per pin; a new level counts only once stages two and three agree.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
            sync3_reg <= SYNC_IDLE;
            filt_reg <= SYNC_IDLE;
        end
        else
        begin
            sync1_reg <= {serialIn, rxBitGateN, txBitGateN, framePulseInN, serialClockIn};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            clkPrev_reg <= 1'b0;
            fpPrev_reg <= 1'b1;
        end
        else
        begin
            clkPrev_reg <= filt_reg[0];
            fpPrev_reg <= filt_reg[1];
        end
    end

    wire clkRise = filt_reg[0] & ~clkPrev_reg;
    wire clkFall = ~filt_reg[0] & clkPrev_reg;
    wire fpFall = ~filt_reg[1] & fpPrev_reg;
    wire internal = timing_reg.internalTiming;
    wire slowRate = internal & ~timing_reg.clockRateSelect;
    wire cpuWr = cpuReq.sel & cpuReq.write;
    wire cpuRd = cpuReq.sel & ~cpuReq.write;
    wire transparent = hstf_fill_t'(control_reg[`HSTF_CTRL_FILL_MSB:`HSTF_CTRL_FILL_LSB])
        == HSTF_FILL_TRANSP;
    wire transpOk = transparent & ~(internal & (timing_reg.timeslotSelect == 4'h0));

    // The 4.096 MHz clock carries one bit per two periods; a frame pulse realigns the phase.
    wire launch = clkRise & (~slowRate | fpSeen_reg | ~halfPhase_reg);
    wire sample = clkFall & (~slowRate | halfPhase_reg);
    wire [7:0] nextPos = fpSeen_reg ? 8'h00 : bitPos_reg + 8'h01;
    wire [3:0] nBits = slotBits(timing_reg.timeslotSelect);
    wire [4:0] dataChan = slotChan(timing_reg.timeslotSelect);
    wire [3:0] bitsPerByte = internal ? nBits : 4'h8;
    wire nextSlot = (nextPos[7:3] == dataChan) && ({1'b0, nextPos[2:0]} < nBits);
    wire nextInCtrl = internal & (nextPos[7:3] == `HSTF_CTRL_CHANNEL);
    wire txOpenNext = internal ? nextSlot : ~filt_reg[2];
    wire rxOpenNext = internal ? nextSlot : ~filt_reg[3];
    wire ctrlBitNow = cchCtrl_reg[nextPos[2:0]];

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            halfPhase_reg <= 1'b0;
            fpSeen_reg <= 1'b0;
            bitPos_reg <= 8'h00;
            rxOpen_reg <= 1'b0;
        end
        else
        begin
            if (clkRise)
            begin
                halfPhase_reg <= slowRate & launch;
            end
            if (fpFall)
            begin
                fpSeen_reg <= 1'b1;
            end
            else if (launch)
            begin
                fpSeen_reg <= 1'b0;
            end
            if (launch)
            begin
                bitPos_reg <= nextPos;
                rxOpen_reg <= rxOpenNext;
            end
        end
    end

    wire txFifoEmpty = (txCount_reg == '0);
    wire txFifoFull = (txCount_reg == CW'(FIFO_DEPTH));
    wire rxFifoEmpty = (rxCount_reg == '0);
    wire rxFifoFull = (rxCount_reg == CW'(FIFO_DEPTH));
    wire txByteEnd = (txCnt_reg == bitsPerByte - 4'h1);
    wire txPop = launch & ~nextInCtrl & txOpenNext & transpOk & txByteEnd & ~txFifoEmpty;
    wire txPush = cpuWr & (cpuReq.addr == `HSTF_ADDR_TX_DATA) & ~txFifoFull;
    wire rxBitTake = sample & rxOpen_reg & transpOk;
    wire rxByteEnd = (rxCnt_reg == bitsPerByte - 4'h1);
    wire rxPush = rxBitTake & rxByteEnd & ~rxFifoFull;
    wire rxPop = cpuRd & (cpuReq.addr == `HSTF_ADDR_RX_DATA) & ~rxFifoEmpty;
    wire [7:0] rxByte = {filt_reg[4], rxShift_reg[7:1]};
    // The control channel keeps its own shifter so packet reception never disturbs it.
    wire [7:0] cchByte = {filt_reg[4], cchShift_reg[7:1]};
    wire [7:0] rxHeadData = rxMem[rxRd_reg].data;
    wire wdClear = cpuWr & (cpuReq.addr == `HSTF_ADDR_WATCHDOG)
        & ((cpuReq.data & `HSTF_WD_KEY_MASK) == `HSTF_WD_KEY_VALUE);

    // Serial launch. Slots that belong to nobody float the line.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            serialOut_reg <= 1'b1;
            serialOutOeN_reg <= 1'b1;
            txShift_reg <= 8'hFF;
            txCnt_reg <= 4'h0;
        end
        else if (launch)
        begin
            if (nextInCtrl)
            begin
                serialOut_reg <= ctrlBitNow;
                serialOutOeN_reg <= ~timing_reg.ctrlChannelTxEnable;
            end
            else if (txOpenNext)
            begin
                serialOutOeN_reg <= 1'b0;
                if (transpOk)
                begin
                    serialOut_reg <= txShift_reg[0];
                    if (txByteEnd)
                    begin
                        txCnt_reg <= 4'h0;
                        txShift_reg <= txFifoEmpty ? lastWritten_reg : txMem[txRd_reg];
                    end
                    else
                    begin
                        txShift_reg <= {1'b1, txShift_reg[7:1]};
                        txCnt_reg <= txCnt_reg + 4'h1;
                    end
                end
                else
                begin
                    // No protocol framing is built; this path idles the line at ones.
                    serialOut_reg <= 1'b1;
                end
            end
            else
            begin
                serialOutOeN_reg <= 1'b1;
            end
        end
    end

    // Serial sample. Short slots leave the received bits in the top of the byte.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            rxShift_reg <= 8'h00;
            rxCnt_reg <= 4'h0;
        end
        else if (rxBitTake)
        begin
            if (rxByteEnd)
            begin
                rxShift_reg <= 8'h00;
                rxCnt_reg <= 4'h0;
            end
            else
            begin
                rxShift_reg <= rxByte;
                rxCnt_reg <= rxCnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            cchShift_reg <= 8'h00;
            cchStatus_reg <= 8'h00;
        end
        else if (sample && internal && bitPos_reg[7:3] == `HSTF_CTRL_CHANNEL)
        begin
            cchShift_reg <= cchByte;
            if (bitPos_reg[2:0] == 3'h7)
            begin
                cchStatus_reg <= cchByte;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (txPush)
        begin
            txMem[txWr_reg] <= cpuReq.data;
        end
        if (rxPush)
        begin
            rxMem[rxWr_reg] <= '{byteStatus: 2'b00, data: rxByte};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            txWr_reg <= '0;
            txRd_reg <= '0;
            txCount_reg <= '0;
            lastWritten_reg <= 8'hFF;
        end
        else
        begin
            if (txPush)
            begin
                txWr_reg <= ptrInc(txWr_reg);
                lastWritten_reg <= cpuReq.data;
            end
            if (txPop)
            begin
                txRd_reg <= ptrInc(txRd_reg);
            end
            if (txPush && !txPop)
            begin
                txCount_reg <= txCount_reg + 1'b1;
            end
            else if (txPop && !txPush)
            begin
                txCount_reg <= txCount_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            rxWr_reg <= '0;
            rxRd_reg <= '0;
            rxCount_reg <= '0;
        end
        else
        begin
            if (rxPush)
            begin
                rxWr_reg <= ptrInc(rxWr_reg);
            end
            if (rxPop)
            begin
                rxRd_reg <= ptrInc(rxRd_reg);
            end
            if (rxPush && !rxPop)
            begin
                rxCount_reg <= rxCount_reg + 1'b1;
            end
            else if (rxPop && !rxPush)
            begin
                rxCount_reg <= rxCount_reg - 1'b1;
            end
        end
    end

    // Status is frozen briefly after each access so software never sees a half-updated fill.
    wire fifoAccess = txPush | txPop | rxPush | rxPop;
    wire [1:0] liveRx = rxFifoEmpty ? 2'b00 : rxFifoFull ? 2'b10 :
        (rxCount_reg >= CW'(`HSTF_RX_HIGH_MARK)) ? 2'b11 : 2'b01;
    wire [1:0] liveTx = txFifoFull ? 2'b00 : txFifoEmpty ? 2'b10 :
        (txCount_reg >= CW'(`HSTF_TX_HIGH_MARK)) ? 2'b01 : 2'b11;
    wire [1:0] headStatus = rxFifoEmpty ? 2'b00 : rxMem[rxRd_reg].byteStatus;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            statDelay_reg <= 3'h0;
            fifoStat_reg <= `HSTF_FIFO_STAT_RST;
        end
        else
        begin
            if (fifoAccess)
            begin
                statDelay_reg <= slowRate ? 3'(`HSTF_STAT_EDGES_FAST)
                    : 3'(`HSTF_STAT_EDGES_SLOW);
            end
            else if (clkFall && statDelay_reg != 3'h0)
            begin
                statDelay_reg <= statDelay_reg - 3'h1;
            end
            if (!fifoAccess && statDelay_reg == 3'h0)
            begin
                fifoStat_reg <= {headStatus, liveRx, liveTx, 2'b00};
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            control_reg <= `HSTF_CONTROL_RST;
            cchCtrl_reg <= `HSTF_CCH_CTRL_RST;
            timing_reg <= hstf_timing_t'(`HSTF_TIMING_RST);
        end
        else if (cpuWr)
        begin
            case (cpuReq.addr)
                `HSTF_ADDR_CONTROL: control_reg <= cpuReq.data;
                `HSTF_ADDR_CCH_CTRL: cchCtrl_reg <= cpuReq.data;
                `HSTF_ADDR_TIMING: timing_reg <= hstf_timing_t'(cpuReq.data);
                default: control_reg <= control_reg;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            cpuRdData_reg <= 8'h00;
        end
        else if (cpuRd)
        begin
            case (cpuReq.addr)
                `HSTF_ADDR_FIFO_STAT: cpuRdData_reg <= fifoStat_reg;
                `HSTF_ADDR_RX_DATA: cpuRdData_reg <= rxHeadData;
                `HSTF_ADDR_CONTROL: cpuRdData_reg <= control_reg;
                `HSTF_ADDR_CCH_CTRL: cpuRdData_reg <= cchCtrl_reg;
                `HSTF_ADDR_TIMING: cpuRdData_reg <= timing_reg;
                `HSTF_ADDR_CCH_STATUS: cpuRdData_reg <= cchStatus_reg;
                default: cpuRdData_reg <= 8'h00;
            endcase
        end
    end

    // The frame pulse runs in both timing modes, so the watchdog counts it unconditionally.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            wdCnt_reg <= 11'h000;
            wdAlarmN_reg <= 1'b1;
        end
        else
        begin
            if (wdClear)
            begin
                wdCnt_reg <= 11'h000;
            end
            else if (fpFall)
            begin
                wdCnt_reg <= wdCnt_reg + 11'h001;
            end
            wdAlarmN_reg <= ~wdCnt_reg[10];
        end
    end

    assign cpuRdData = cpuRdData_reg;
    assign serialOut = serialOut_reg;
    assign serialOutOeN = serialOutOeN_reg;
    assign watchdogAlarmN = wdAlarmN_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    status_low_zero_a: assert property (fifoStat_reg[1:0] == 2'b00)
        else $error("FIFO status low bits not zero.");
    ctrl_slot_float_a: assert property (launch && nextInCtrl && !timing_reg.ctrlChannelTxEnable
        |=> serialOutOeN_reg)
        else $error("Channel one driven while disabled.");
    ctrl_slot_drive_a: assert property (launch && nextInCtrl && timing_reg.ctrlChannelTxEnable
        |=> !serialOutOeN_reg && serialOut_reg == $past(ctrlBitNow))
        else $error("Control byte bit not launched in channel one.");
    idle_slot_float_a: assert property (launch && internal && !nextSlot && !nextInCtrl
        |=> serialOutOeN_reg)
        else $error("Output driven outside selected timeslots.");
    launch_only_a: assert property (!launch |=> $stable(serialOut_reg))
        else $error("Serial output changed away from a launch edge.");
    wd_clear_idle_a: assert property (wdClear |-> ##2 wdAlarmN_reg [*8])
        else $error("Watchdog alarm low right after a clear.");
    rx_pop_data_a: assert property (rxPop |=> cpuRdData_reg == $past(rxHeadData))
        else $error("Receive read did not return the oldest byte.");
    rx_pop_count_a: assert property (rxPop && !rxPush
        |=> rxCount_reg == $past(rxCount_reg) - CW'(1))
        else $error("Receive read did not remove a byte.");
    status_hold_a: assert property (statDelay_reg != 3'h0 |=> $stable(fifoStat_reg))
        else $error("FIFO status updated before its delay ran out.");
endmodule

// ### verif/hstf_tdm_partner.sv
`timescale 1ns/1ps
module hstf_tdm_partner (
    output logic sclk,
    output logic fpN,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdoOeN
);
    int frameBits = 256;
    int pos = 0;
    logic outBit[256];
    logic outOe[256];
    logic inBits[256];
    initial
    begin
        sclk = 0;
        fpN = 1;
        sdi = 1;
        #7;
        forever
        begin
            #80 sclk = 1;
            outBit[pos] = sdo;
            outOe[pos] = sdoOeN;
            pos = (pos >= frameBits - 1) ? 0 : pos + 1;
            // Data changes on the launch edge so it is steady at the falling sample edge.
            sdi = inBits[pos];
            #80 sclk = 0;
            fpN = (pos == frameBits - 1) ? 1'b0 : 1'b1;
        end
    end
endmodule

// ### verif/hstf_top_test.sv
`timescale 1ns/1ps
`include "hstf_regs.svh"
module hstf_top_test;
    import hstf_pkg::*;
    logic core_clk = 0;
    logic rstn = 0;
    hstf_cpu_req_t cpuReq = '0;
    logic [7:0] cpuRdData;
    logic txBitGateN = 1;
    logic rxBitGateN = 1;
    logic sclk, fpN, sdi, sdo, oeN, wdN;
    int bad_count = 0;
    int checks_done = 0;
    int cnt;
    logic [7:0] rd, x, y, z, w;
    logic [7:0] txQ[$];
    logic [7:0] rxQ[$];
    always #10 core_clk = ~core_clk;
    hstf_top dut (.core_clk(core_clk), .rstn(rstn), .cpuReq(cpuReq), .cpuRdData(cpuRdData),
        .serialClockIn(sclk), .framePulseInN(fpN), .txBitGateN(txBitGateN),
        .rxBitGateN(rxBitGateN), .serialIn(sdi), .serialOut(sdo), .serialOutOeN(oeN),
        .watchdogAlarmN(wdN));
    hstf_tdm_partner p (.sclk(sclk), .fpN(fpN), .sdi(sdi), .sdo(sdo), .sdoOeN(oeN));
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cpu(input logic wr, input logic [3:0] ad, input logic [7:0] d);
        @(posedge core_clk) #2 cpuReq = '{1'b1, wr, ad, d};
        @(posedge core_clk) #2 cpuReq.sel = 1'b0;
        rd = cpuRdData;
    endtask
    task automatic reset();
        @(posedge core_clk) #2 rstn = 0;
        repeat (3) @(posedge core_clk);
        #2 rstn = 1;
    endtask
    task automatic atPos(input int q);
        do @(posedge sclk) #1; while (p.pos != q);
        @(posedge core_clk) #2;
    endtask
    // Status counts settle only after serial clock falls, so each read waits five bits.
    task automatic stat(input logic [7:0] e);
        repeat (5) @(posedge sclk);
        cpu(0, `HSTF_ADDR_FIFO_STAT, 8'h00);
        check("status", rd, e);
    endtask
    function automatic logic [7:0] getb(input int k, input bit oe);
        for (int i = 0; i < 8; i++)
            getb[i] = oe ? p.outOe[k + i] : p.outBit[k + i];
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'h4eb8));
        foreach (p.inBits[i])
            p.inBits[i] = 1'($urandom);
        reset();
        stat(8'h08);
        check("alarm", {7'h00, wdN}, 8'h01);
        for (int i = 7; i < 16; i++)
        begin
            cpu(0, i[3:0], 8'hFF);
            check("unmapped", rd, 8'h00);
        end
        cpu(1, `HSTF_ADDR_CONTROL, 8'h08);
        cpu(1, `HSTF_ADDR_TIMING, 8'h00);
        for (int i = 0; i < 20; i++)
        begin
            x = 8'($urandom);
            if (i < 19)
                txQ.push_back(x);
            cpu(1, `HSTF_ADDR_TX_DATA, x);
            if (i == 0)
            begin
                cpu(0, `HSTF_ADDR_FIFO_STAT, 8'h00);
                check("status early", rd, 8'h08);
            end
            if (i == 1)
                stat(8'h0C);
            if (i == 4)
                stat(8'h04);
        end
        stat(8'h00);
        atPos(255);
        txBitGateN = 0;
        atPos(255);
        cnt = -1;
        for (int k = 15; k >= 0; k--)
            if (getb(k, 0) === txQ[0] && getb(k + 8, 0) === txQ[1])
                cnt = k;
        check("tx align", {7'h00, cnt >= 0}, 8'h01);
        if (cnt < 0)
            cnt = 0;
        for (int i = 0; i < 21; i++)
            check("tx byte", getb(cnt + 8 * i, 0), txQ[i < 19 ? i : 18]);
        check("tx drive", getb(cnt + 40, 1), 8'h00);
        for (int i = 0; i < 19; i++)
        begin
            x = 8'($urandom);
            rxQ.push_back(x);
            for (int j = 0; j < 8; j++)
                p.inBits[8 * i + j] = x[j];
        end
        rxBitGateN = 0;
        atPos(151);
        rxBitGateN = 1;
        stat(8'h28);
        for (int i = 19; i > 0; i--)
        begin
            cpu(0, `HSTF_ADDR_RX_DATA, 8'h00);
            check("rx byte", rd, rxQ.pop_front());
            if (i == 16)
                stat(8'h38);
            if (i == 15)
                stat(8'h18);
        end
        stat(8'h08);
        reset();
        x = 8'($urandom);
        y = 8'($urandom);
        z = 8'($urandom);
        w = 8'($urandom);
        for (int j = 0; j < 8; j++)
        begin
            p.inBits[8 + j] = z[j];
            p.inBits[16 + j] = w[j];
        end
        txBitGateN = 1;
        // Wait for a frame pulse so the slot counter is aligned before slots open.
        atPos(255);
        cpu(1, `HSTF_ADDR_CONTROL, 8'h08);
        cpu(1, `HSTF_ADDR_CCH_CTRL, x);
        cpu(1, `HSTF_ADDR_TX_DATA, y);
        cpu(1, `HSTF_ADDR_TIMING, 8'h74);
        atPos(255);
        atPos(255);
        for (int c = 0; c < 32; c++)
            check("slot oe", getb(8 * c, 1), (c == 1 || c == 2) ? 8'h00 : 8'hFF);
        check("ch1 out", getb(8, 0), x);
        check("ch2 out", getb(16, 0), y);
        for (int i = 0; i < 4; i++)
            cpu(0, `HSTF_ADDR_RX_DATA, 8'h00);
        atPos(40);
        cpu(0, `HSTF_ADDR_RX_DATA, 8'h00);
        check("ch2 in", rd, w);
        cpu(0, `HSTF_ADDR_CCH_STATUS, 8'h00);
        check("ch1 in", rd, z);
        cpu(1, `HSTF_ADDR_TIMING, 8'h54);
        atPos(255);
        atPos(255);
        check("ch1 float", getb(8, 1), 8'hFF);
        check("ch2 drive", getb(16, 1), 8'h00);
        cpu(1, `HSTF_ADDR_TIMING, 8'h71);
        atPos(255);
        atPos(255);
        check("short oe", getb(16, 1), 8'hFC);
        check("short out", {6'h00, p.outBit[17], p.outBit[16]}, {6'h00, y[1:0]});
        cpu(0, `HSTF_ADDR_RX_DATA, 8'h00);
        check("full in", rd, w);
        cpu(0, `HSTF_ADDR_RX_DATA, 8'h00);
        check("short in", rd, {w[1:0], 6'h00});
        p.frameBits = 2;
        @(posedge fpN);
        reset();
        cnt = 0;
        for (int i = 0; i < 2400; i++)
        begin
            @(negedge fpN);
            cnt = (cnt + 1) % 2048;
            repeat (12) @(posedge core_clk);
            #2 check("alarm", {7'h00, wdN}, {7'h00, ~cnt[10]});
            if (i == 300)
            begin
                cpu(1, `HSTF_ADDR_WATCHDOG, {3'($urandom), 5'h0A});
                cnt = 0;
            end
            if (i == 600)
                cpu(1, `HSTF_ADDR_WATCHDOG, 8'h1A);
        end
        wrap_up();
    end
    initial
    begin
        #2_000_000;
        bad_count++;
        wrap_up();
    end
endmodule
